// *** bench/ome_file_model.sv ***
// Purpose: data file register model for the execute bench
// Assumes: read is combinational, write lands on the clock edge
// Notes:   no bypass, so a write is seen from the next cycle on
`timescale 1ns/1ns
module ome_file_model
  import ome_pkg::*;
(
  // clock
  input  wire logic                       clock,
  // read side
  input  wire logic [ome_pkg::ADDR_W-1:0] raddr,
  output logic      [ome_pkg::DATA_W-1:0] rdata,
  // write side
  input  wire logic                       we,
  input  wire logic [ome_pkg::ADDR_W-1:0] waddr,
  input  wire logic [ome_pkg::DATA_W-1:0] wdata
);
  // ==========================================================
  // storage, cleared so no read ever returns unknowns
  logic [7:0] mem [128];
  initial begin
    for (int i = 0; i < 128; i++) begin
      mem[i] = 8'h00;
    end
  end
  assign rdata = mem[raddr];
  always @(posedge clock) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end
endmodule : ome_file_model

// *** bench/or_move_instruction_execute_bench.sv ***
// Purpose: self-checking bench for the execute datapath
// Assumes: one instruction at a time, answer one cycle after taking
// Notes:   file contents are set up through store instructions
`timescale 1ns/1ns
module or_move_instruction_execute_bench;
  import ome_pkg::*;
  // ==========================================================
  // signals
  logic        clock       = 1'b0;
  logic        reset_n     = 1'b0;
  logic        instr_valid = 1'b0;
  logic [13:0] instr_word  = 14'h0000;
  logic [6:0]  file_addr, file_waddr;
  logic [7:0]  file_rdata, file_wdata, accumulator;
  logic        file_we, zero_flag, pc_advance;
  int          err_count   = 0;
  int          n_tests     = 0;
  always #2 clock = ~clock;
  ome_execute i_ome_execute (.clock(clock), .reset_n(reset_n), .instr_valid(instr_valid),
    .instr_word(instr_word), .file_addr(file_addr), .file_rdata(file_rdata), .file_we(file_we),
    .file_waddr(file_waddr), .file_wdata(file_wdata), .accumulator(accumulator),
    .zero_flag(zero_flag), .pc_advance(pc_advance));
  ome_file_model i_ome_file_model (.clock(clock), .raddr(instr_word[6:0]), .rdata(file_rdata),
    .we(file_we), .waddr(file_waddr), .wdata(file_wdata));
  // ==========================================================
  // shared tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // issue one word, then judge the state one cycle after it is taken
  task automatic run(input logic [13:0] w, input logic [7:0] acc, input logic z, input logic we,
                     input logic [7:0] wd);
    @(posedge clock);
    instr_valid <= 1'b1;
    instr_word  <= w;
    @(posedge clock);
    instr_valid <= 1'b0;
    #1;
    chk(accumulator, acc);
    chk({7'h00, zero_flag}, {7'h00, z});
    chk({7'h00, file_we}, {7'h00, we});
    chk({7'h00, pc_advance}, 8'h01);
    chk({1'h0, file_addr}, {1'h0, w[6:0]});
    if (we) begin
      chk({1'h0, file_waddr}, {1'h0, w[6:0]});
      chk(file_wdata, wd);
    end
  endtask : run
  task automatic end_of_test;
    if (err_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test
  // ==========================================================
  // scenarios
  task automatic load_and_store;
    run({4'hC, 2'h0, 8'h5A}, 8'h5A, 1'b0, 1'b0, 8'h00);
    run({6'h00, 1'b1, 7'h7F}, 8'h5A, 1'b0, 1'b1, 8'h5A);
    run({4'hC, 2'h0, 8'h00}, 8'h00, 1'b0, 1'b0, 8'h00);
    run({6'h00, 1'b1, 7'h10}, 8'h00, 1'b0, 1'b1, 8'h00);
    run({6'h04, 1'b0, 7'h10}, 8'h00, 1'b1, 1'b0, 8'h00);
  endtask : load_and_store
  // the load must keep the zero flag that the last OR set
  task automatic or_both_dest;
    run({4'hC, 2'h0, 8'h0F}, 8'h0F, 1'b1, 1'b0, 8'h00);
    run({6'h04, 1'b1, 7'h7F}, 8'h0F, 1'b0, 1'b1, 8'h0F | 8'h5A);
    run({6'h04, 1'b0, 7'h7F}, 8'h0F | 8'h5F, 1'b0, 1'b0, 8'h00);
  endtask : or_both_dest
  // zero test in place, then flags must survive store and load
  task automatic move_zero_test;
    run({6'h08, 1'b1, 7'h10}, 8'h5F, 1'b1, 1'b1, 8'h00);
    run({6'h00, 1'b1, 7'h10}, 8'h5F, 1'b1, 1'b1, 8'h5F);
    run({4'hC, 2'h0, 8'h80}, 8'h80, 1'b1, 1'b0, 8'h00);
    run({6'h08, 1'b0, 7'h7F}, 8'h5F, 1'b0, 1'b0, 8'h00);
  endtask : move_zero_test
  // unsupported words act as no-op; idle cycles ignore even a store word
  task automatic nop_idle;
    run(14'h0000, 8'h5F, 1'b0, 1'b0, 8'h00);
    run(14'h3FFF, 8'h5F, 1'b0, 1'b0, 8'h00);
    @(posedge clock);
    instr_word <= {6'h00, 1'b1, 7'h20};
    repeat (2) @(posedge clock);
    #1;
    chk({6'h00, file_we, pc_advance}, 8'h00);
    chk(accumulator, 8'h5F);
  endtask : nop_idle
  // back-to-back words: the store takes the literal loaded one edge before
  task automatic back_to_back;
    @(posedge clock);
    instr_valid <= 1'b1;
    instr_word  <= {4'hC, 2'h0, 8'hA5};
    @(posedge clock);
    instr_word  <= {6'h00, 1'b1, 7'h21};
    @(posedge clock);
    instr_valid <= 1'b0;
    #1;
    chk(accumulator, 8'hA5);
    chk({7'h00, file_we}, 8'h01);
    chk({1'h0, file_waddr}, 8'h21);
    chk(file_wdata, 8'hA5);
  endtask : back_to_back
  // reset in mid-run clears the state; the file itself keeps its contents
  task automatic reset_mid;
    @(posedge clock);
    reset_n <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    chk(accumulator, ACC_RESET);
    chk({5'h00, file_we, zero_flag, pc_advance}, 8'h00);
    @(posedge clock);
    reset_n <= 1'b1;
    run({6'h08, 1'b0, 7'h7F}, 8'h5F, 1'b0, 1'b0, 8'h00);
  endtask : reset_mid
  // ==========================================================
  // main sequence
  initial begin
    repeat (10) @(posedge clock);
    reset_n <= 1'b1;
    #1;
    chk(accumulator, ACC_RESET);
    load_and_store();
    or_both_dest();
    move_zero_test();
    nop_idle();
    back_to_back();
    reset_mid();
    end_of_test();
  end
endmodule : or_move_instruction_execute_bench

// *** logic/ome_decode.sv ***
// Purpose: classify an instruction word into one supported operation
// Assumes: word is stable while valid is high
// Notes:   unsupported words decode as no-operation
`timescale 1ns/1ns
module ome_decode
  import ome_pkg::*;
(
  // instruction
  input  wire logic [ome_pkg::WORD_W-1:0] word,
  // decoded
  output ome_pkg::ome_op_e                op
);

  always_comb begin
    op = OME_NOP;
    if (word[OP6_HI:OP6_LO] == OP_OR_FILE) begin
      op = OME_OR;
    end else if (word[OP6_HI:OP6_LO] == OP_MOVE_FILE) begin
      op = OME_MOVE;
    end else if (word[OP6_HI:OP6_LO] == OP_STORE_BASE && word[DEST_BIT]) begin
      op = OME_STORE;
    end else if (word[OP6_HI:OP4_LO] == OP_LOAD_LIT) begin
      op = OME_LOAD;
    end
  end

endmodule : ome_decode

// *** logic/ome_execute.sv ***
// Purpose: single-cycle execute stage for OR, move, store, load-literal, no-op
// Assumes: file read data is combinational from the word's address field in the same cycle; file_addr is its registered copy
// Notes:   one instruction per clock, results registered on the next edge
`timescale 1ns/1ns

// What this block does
// RL1 - OR accumulator with addressed file register, 7-bit address, zero flag from result
// RL2 - OR result goes to accumulator when d is 0, to file when 1
// RL3 - move file to accumulator or back to itself, one word one cycle
// RL4 - move updates zero flag from moved value, allowing zero test in place
// RL5 - store accumulator into addressed file, flags unchanged, one cycle
// RL6 - load 8-bit literal into accumulator, flags unchanged, one cycle
// RL7 - no-op changes nothing, one cycle, program counter only advances
module ome_execute
  import ome_pkg::*;
(
  // clock and reset
  input  wire logic                        clock,
  input  wire logic                        reset_n,
  // instruction from fetch, decoded here by ome_decode
  input  wire logic                        instr_valid,
  input  wire logic [ome_pkg::WORD_W-1:0]  instr_word,
  // file register read path
  output logic      [ome_pkg::ADDR_W-1:0]  file_addr,
  input  wire logic [ome_pkg::DATA_W-1:0]  file_rdata,
  // file register write path
  output logic                             file_we,
  output logic      [ome_pkg::ADDR_W-1:0]  file_waddr,
  output logic      [ome_pkg::DATA_W-1:0]  file_wdata,
  // architectural state
  output logic      [ome_pkg::DATA_W-1:0]  accumulator,
  output logic                             zero_flag,
  output logic                             pc_advance
);

  ome_op_e                 op;
  logic    [ADDR_W-1:0]    addr_now;
  logic                    dest_file;
  logic    [DATA_W-1:0]    literal;
  logic    [DATA_W-1:0]    result;
  logic                    writes_file;
  logic                    writes_acc;
  logic                    writes_zero;

  // ==========================================================
  // helpers
  // one definition of zero for the flag and for the OR zero check
  function automatic logic is_zero(input logic [DATA_W-1:0] value);
    return value == '0;
  endfunction : is_zero

  // decoder is pure logic; its op is only trusted while instr_valid is high
  ome_decode i_ome_decode (
    .word (instr_word),
    .op   (op)
  );

  // ==========================================================
  // operand fields
  assign addr_now  = instr_word[ADDR_W-1:0];
  assign dest_file = instr_word[DEST_BIT];
  assign literal   = instr_word[DATA_W-1:0];

  // read address follows the word directly; registered copy is the output
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      file_addr <= ADDR_RESET;
    end else begin
      file_addr <= addr_now;
    end
  end

  // ==========================================================
  // result and destination
  // limitation: no bypass, so a word reading the register written by the
  // word just before it sees the old value; software must space them
  always_comb begin
    result      = literal;
    writes_file = 1'b0;
    writes_acc  = 1'b0;
    writes_zero = 1'b0;
    if (instr_valid) begin
      case (op)
        OME_OR: begin
          result      = accumulator | file_rdata; // [RL1]
          writes_zero = 1'b1;                     // [RL1]
          writes_file = dest_file;                // [RL2]
          writes_acc  = !dest_file;               // [RL2]
        end
        OME_MOVE: begin
          result      = file_rdata;               // [RL3]
          writes_zero = 1'b1;                     // [RL4]
          writes_file = dest_file;                // [RL3]
          writes_acc  = !dest_file;               // [RL3]
        end
        OME_STORE: begin
          result      = accumulator;              // [RL5]
          writes_file = 1'b1;                     // [RL5]
        end
        OME_LOAD: begin
          result      = literal;                  // [RL6]
          writes_acc  = 1'b1;                     // [RL6]
        end
        default: begin
          result      = literal;                  // [RL7]
        end
      endcase
    end
  end

  // ==========================================================
  // accumulator
  // only OR and move with d clear, and load, reach the accumulator
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      accumulator <= ACC_RESET;
    end else if (writes_acc) begin
      accumulator <= result;
    end
  end

  // zero flag, held by store, load and no-op
  // d only picks the destination; the flag follows the result either way
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      zero_flag <= 1'b0;
    end else if (writes_zero) begin
      zero_flag <= is_zero(result); // [RL1] [RL4]
    end
  end

  // ==========================================================
  // file write port, registered so outputs come from flops
  // address and data load every cycle; only file_we qualifies them, saving enables
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      file_we    <= 1'b0;
      file_waddr <= ADDR_RESET;
      file_wdata <= ACC_RESET;
    end else begin
      file_we    <= writes_file;
      file_waddr <= addr_now;
      file_wdata <= result;
    end
  end

  // every accepted instruction completes in one cycle
  // unknown words still advance, so the decoder never stalls the fetch
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pc_advance <= 1'b0;
    end else begin
      pc_advance <= instr_valid; // [RL3] [RL5] [RL6] [RL7]
    end
  end

  // ==========================================================
  // checks
  // every check looks one edge after the word is taken, where the registered outputs answer
  or_to_acc_a : assert property (@(posedge clock) disable iff (!reset_n) // [RL1]
    instr_valid && op == OME_OR && !dest_file |=> accumulator == ($past(accumulator) | $past(file_rdata)))
    else $error("or result not in accumulator");
  or_to_file_a : assert property (@(posedge clock) disable iff (!reset_n) // [RL2]
    instr_valid && op == OME_OR && dest_file |=> file_we && accumulator == $past(accumulator)
      && file_wdata == ($past(accumulator) | $past(file_rdata)))
    else $error("or result not written to file");
  or_zero_a : assert property (@(posedge clock) disable iff (!reset_n) // [RL1]
    instr_valid && op == OME_OR |=> zero_flag == is_zero($past(accumulator) | $past(file_rdata)))
    else $error("or zero flag wrong");
  move_dest_a : assert property (@(posedge clock) disable iff (!reset_n) // [RL3]
    instr_valid && op == OME_MOVE |=> (file_we == $past(dest_file)) && pc_advance)
    else $error("move destination wrong");
  move_value_a : assert property (@(posedge clock) disable iff (!reset_n) // [RL3]
    instr_valid && op == OME_MOVE && !dest_file |=> accumulator == $past(file_rdata) && !file_we)
    else $error("move to accumulator wrong");
  move_zero_a : assert property (@(posedge clock) disable iff (!reset_n) // [RL4]
    instr_valid && op == OME_MOVE |=> zero_flag == ($past(file_rdata) == 8'h00))
    else $error("move zero flag wrong");
  move_back_a : assert property (@(posedge clock) disable iff (!reset_n) // [RL3]
    instr_valid && op == OME_MOVE && dest_file |=> file_wdata == $past(file_rdata) && $stable(accumulator)
      && file_waddr == $past(addr_now))
    else $error("move back to file wrong");
  store_file_a : assert property (@(posedge clock) disable iff (!reset_n) // [RL5]
    instr_valid && op == OME_STORE |=> file_we && file_wdata == $past(accumulator) && $stable(zero_flag)
      && file_waddr == $past(addr_now))
    else $error("store wrong");
  store_hold_a : assert property (@(posedge clock) disable iff (!reset_n) // [RL5]
    instr_valid && op == OME_STORE |=> $stable(accumulator) && pc_advance)
    else $error("store changed accumulator");
  load_lit_a : assert property (@(posedge clock) disable iff (!reset_n) // [RL6]
    instr_valid && op == OME_LOAD |=> accumulator == $past(literal) && $stable(zero_flag) && !file_we)
    else $error("load literal wrong");
  nop_quiet_a : assert property (@(posedge clock) disable iff (!reset_n) // [RL7]
    instr_valid && op == OME_NOP |=> !file_we && $stable(accumulator) && $stable(zero_flag) && pc_advance)
    else $error("no-op changed state");
  idle_quiet_a : assert property (@(posedge clock) disable iff (!reset_n) // [RL7]
    !instr_valid |=> !file_we && !pc_advance && $stable(accumulator))
    else $error("idle cycle changed state");

  // ==========================================================
  // checks on addressing and instruction pacing
  addr_copy_a : assert property (@(posedge clock) disable iff (!reset_n) // [RL1]
    instr_valid |=> file_addr == $past(addr_now))
    else $error("file address copy wrong");
  pc_pulse_a : assert property (@(posedge clock) disable iff (!reset_n) // [RL7]
    instr_valid |=> pc_advance)
    else $error("accepted word did not advance");
  write_cause_a : assert property (@(posedge clock) disable iff (!reset_n) // [RL7]
    file_we |-> $past(instr_valid))
    else $error("file write without an instruction");

  // ==========================================================
  // scenario covers
  or_zero_c : cover property (@(posedge clock) disable iff (!reset_n)
    instr_valid && op == OME_OR ##1 zero_flag);
  move_self_c : cover property (@(posedge clock) disable iff (!reset_n)
    instr_valid && op == OME_MOVE && dest_file);
  store_load_c : cover property (@(posedge clock) disable iff (!reset_n)
    instr_valid && op == OME_LOAD ##1 instr_valid && op == OME_STORE);
  nop_c : cover property (@(posedge clock) disable iff (!reset_n)
    instr_valid && op == OME_NOP ##1 pc_advance);
  move_acc_c : cover property (@(posedge clock) disable iff (!reset_n)
    instr_valid && op == OME_MOVE && !dest_file);

endmodule : ome_execute

// *** logic/ome_pkg.sv ***
// Purpose: constants and types shared by the execute datapath files
// Assumes: 14-bit instruction words, 8-bit data, 7-bit file address
// Notes:   opcode fields follow the mid-range 14-bit word layout
package ome_pkg;

  // ==========================================================
  // widths and field positions
  localparam int         WORD_W      = 14;
  localparam int         DATA_W      = 8;
  localparam int         ADDR_W      = 7;
  localparam int         DEST_BIT    = 7;
  localparam int         OP6_HI      = 13;
  localparam int         OP6_LO      = 8;
  localparam int         OP4_LO      = 10;

  // ==========================================================
  // opcode values
  localparam logic [5:0] OP_OR_FILE    = 6'h04;
  localparam logic [5:0] OP_MOVE_FILE  = 6'h08;
  localparam logic [5:0] OP_STORE_BASE = 6'h00;
  localparam logic [3:0] OP_LOAD_LIT   = 4'hC;

  // ==========================================================
  // reset values
  localparam logic [7:0] ACC_RESET   = 8'h00;
  localparam logic [6:0] ADDR_RESET  = 7'h00;

  // decoded operation, one-hot
  typedef enum logic [4:0] {
    OME_NOP   = 5'b00001,
    OME_OR    = 5'b00010,
    OME_MOVE  = 5'b00100,
    OME_STORE = 5'b01000,
    OME_LOAD  = 5'b10000
  } ome_op_e;

endpackage : ome_pkg
